// ==== src/hwm_pkg.sv ====
package hwm_pkg;
    // synchroniser vector layout for the pins sampled on CLK
    localparam int SY_RX_SEL = 0;
    localparam int SY_PASS_SEL = 2;
    localparam int SY_SYS_CLK = 4;
    localparam int SY_PLL_LOCK = 5;
    localparam int SY_DATA_STRAP = 6;
    localparam int SY_SIDE_STRAP = 7;
    localparam int SY_BLOCK_STRAP = 8;
    localparam int SYNC_W = 9;
    // link side pin synchroniser layout
    localparam int LP_BIT_CLK = 0;
    localparam int LP_WORD_CLK = 1;
    localparam int LP_W = 2;
    // last settle count before the straps are taken: one hold cycle, then four settle cycles
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // link divider: bit and word clock taps for each master clock ratio
    localparam int DIV_W = 8;
    localparam int BCLK_TAP_256 = 1;
    localparam int WCLK_TAP_256 = 7;
    localparam int BCLK_TAP_128 = 0;
    localparam int WCLK_TAP_128 = 6;
    // audio word and slot widths on the serial output
    localparam int WORD_W = 24;
    localparam int SLOT_W = 32;
    localparam int PAD_W = SLOT_W - WORD_W;
    localparam logic [PAD_W-1:0] PAD_ZERO = 8'h00;

    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_SETTLE = 2'b01,
        ST_SAMPLE = 2'b11,
        ST_RUN = 2'b10
    } hwm_state_t;

    typedef struct packed {
        logic hw_mode;
        logic rate_128;
        logic port_master;
    } hwm_strap_t;

    typedef struct packed {
        logic [1:0] rx_sel;
        logic [1:0] pass_sel;
    } hwm_sel_t;

    typedef struct packed {
        logic [WORD_W-1:0] left;
        logic [WORD_W-1:0] right;
    } hwm_frame_t;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] f;
        hwm_state_t st;
        logic [1:0] cnt;
        hwm_strap_t strap;
        hwm_sel_t sel;
        logic local_en;
        logic route;
        logic low_power;
        logic block_out;
        logic side_out;
    } hwm_sys_t;

    typedef struct packed {
        logic [3:0] x1;
        logic [3:0] x2;
        logic [3:0] x3;
        logic [3:0] xf;
        logic [LP_W-1:0] p1;
        logic [LP_W-1:0] p2;
        logic [LP_W-1:0] p3;
        logic [LP_W-1:0] pf;
        logic [DIV_W-1:0] div;
        logic bclk_prev;
        logic wclk_prev;
        logic [SLOT_W-1:0] shift;
        logic sdata;
    } hwm_lnk_t;
endpackage : hwm_pkg

// ==== src/hwm_top.sv ====
`timescale 1ns/1ns
module hwm_top
    import hwm_pkg::*;
(
    // system clock domain
    input wire logic CLK,
    input wire logic RST_N,
    // link clock from the recovery loop
    input wire logic MASTER_CLK,
    // line inputs and muxes
    input wire logic [3:0] POSITIVE_LINE_INPUTS,
    input wire logic [1:0] RECEIVER_INPUT_SELECT,
    input wire logic [1:0] PASSTHROUGH_SELECT,
    output logic RECEIVER_LINE,
    output logic PASSTHROUGH_OUT,
    // clock selection
    input wire logic SYSTEM_CLOCK_IN,
    input wire logic PLL_LOCKED,
    output logic RECOVERED_MASTER_CLOCK,
    output logic LOCAL_CLOCK_ACTIVE,
    // strap pins that turn into outputs
    input wire logic BLOCK_START_INDICATOR_IN,
    output logic BLOCK_START_INDICATOR_OUT,
    output logic BLOCK_START_INDICATOR_OE,
    input wire logic BLOCK_START_VALUE,
    input wire logic SIDEBAND_BITS_IN,
    output logic SIDEBAND_BITS_OUT,
    output logic SIDEBAND_BITS_OE,
    input wire logic SIDEBAND_VALUE,
    // serial output port, link domain
    input wire logic SERIAL_OUT_BIT_CLOCK_IN,
    output logic SERIAL_OUT_BIT_CLOCK_OUT,
    output logic SERIAL_OUT_BIT_CLOCK_OE,
    input wire logic SERIAL_OUT_WORD_CLOCK_IN,
    output logic SERIAL_OUT_WORD_CLOCK_OUT,
    output logic SERIAL_OUT_WORD_CLOCK_OE,
    input wire logic SERIAL_OUT_DATA_IN,
    output logic SERIAL_OUT_DATA_OUT,
    output logic SERIAL_OUT_DATA_OE,
    input wire hwm_pkg::hwm_frame_t FRAME,
    // status
    output logic HW_MODE,
    output logic PLL_RATE_128,
    output logic PORT_MASTER,
    output logic LOW_POWER
);
    import hwm_pkg::*;

    hwm_sys_t s;
    hwm_sys_t next_s;
    hwm_lnk_t l;
    hwm_lnk_t next_l;
    logic [SYNC_W-1:0] next_f;
    logic [LP_W-1:0] next_pf;
    logic [3:0] next_xf;
    logic [SYNC_W-1:0] pins;
    logic [1:0] lrst;
    logic lrst_n;
    logic sys_rise;

    assign pins = {BLOCK_START_INDICATOR_IN, SIDEBAND_BITS_IN,
                   SERIAL_OUT_DATA_IN, PLL_LOCKED, SYSTEM_CLOCK_IN,
                   PASSTHROUGH_SELECT, RECEIVER_INPUT_SELECT};

    // a change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sys_filt
            assign next_f[gi] = (s.s2[gi] == s.s3[gi]) ? s.s3[gi] : s.f[gi];
        end
        for (gi = 0; gi < LP_W; gi++) begin : g_lnk_filt
            assign next_pf[gi] = (l.p2[gi] == l.p3[gi]) ? l.p3[gi] : l.pf[gi];
        end
        // run and straps come from the other clock, filtered like a pin
        for (gi = 0; gi < 4; gi++) begin : g_run_filt
            assign next_xf[gi] = (l.x2[gi] == l.x3[gi]) ? l.x3[gi] : l.xf[gi];
        end
    endgenerate

    assign sys_rise = next_f[SY_SYS_CLK] & ~s.f[SY_SYS_CLK];

    always_comb begin
        next_s = s;
        next_s.s1 = pins;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        next_s.f = next_f;
        next_s.block_out = BLOCK_START_VALUE;
        next_s.side_out = SIDEBAND_VALUE;
        case (s.st)
            ST_HOLD: begin
                next_s.st = ST_SETTLE;
            end
            ST_SETTLE: begin
                next_s.cnt = s.cnt + 2'h1;
                if (s.cnt == STRAP_SETTLE) begin
                    next_s.st = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                // straps are taken once, straight after the settle count
                next_s.strap.hw_mode = ~s.f[SY_DATA_STRAP];
                next_s.strap.rate_128 = s.f[SY_SIDE_STRAP];
                next_s.strap.port_master = s.f[SY_BLOCK_STRAP];
                next_s.low_power = 1'b0;
                next_s.st = ST_RUN;
            end
            ST_RUN: begin
                next_s.sel.rx_sel = s.f[SY_RX_SEL +: 2];
                next_s.sel.pass_sel = s.f[SY_PASS_SEL +: 2];
                if (sys_rise) begin
                    next_s.local_en = 1'b1;
                end
                next_s.route = s.local_en & ~s.f[SY_PLL_LOCK];
            end
            default: begin
                next_s.st = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s <= '0;
            s.low_power <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // raw line waveforms are muxed, not sampled: 20 MHz cannot carry them
    always_comb begin
        RECEIVER_LINE = 1'b0;
        PASSTHROUGH_OUT = 1'b0;
        if (!s.low_power && s.strap.hw_mode) begin
            RECEIVER_LINE = POSITIVE_LINE_INPUTS[s.sel.rx_sel];
            PASSTHROUGH_OUT = POSITIVE_LINE_INPUTS[s.sel.pass_sel];
        end
    end

    // select is a CLK flop; the swap may clip one cycle, as on the real pin
    assign RECOVERED_MASTER_CLOCK = s.route ? SYSTEM_CLOCK_IN : MASTER_CLK;
    assign LOCAL_CLOCK_ACTIVE = s.route;
    assign BLOCK_START_INDICATOR_OUT = s.block_out;
    assign BLOCK_START_INDICATOR_OE = ~s.low_power;
    assign SIDEBAND_BITS_OUT = s.side_out;
    assign SIDEBAND_BITS_OE = ~s.low_power;
    assign HW_MODE = s.strap.hw_mode;
    assign PLL_RATE_128 = s.strap.rate_128;
    assign PORT_MASTER = s.strap.port_master;
    assign LOW_POWER = s.low_power;

    // link side reset: asserted at once, released on MASTER_CLK
    always_ff @(posedge MASTER_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lrst <= 2'h0;
        end else begin
            lrst <= {lrst[0], 1'b1};
        end
    end
    assign lrst_n = lrst[1];

    logic run_l;
    hwm_strap_t strap_l;
    logic bclk_m;
    logic wclk_m;
    logic bclk_c;
    logic wclk_c;
    logic bclk_fall;
    logic [SLOT_W-1:0] load;

    // run and straps as seen on the link clock
    assign run_l = l.xf[3];
    assign strap_l = l.xf[2:0];
    assign bclk_m = strap_l.rate_128 ? l.div[BCLK_TAP_128]
                                     : l.div[BCLK_TAP_256];
    assign wclk_m = strap_l.rate_128 ? l.div[WCLK_TAP_128]
                                     : l.div[WCLK_TAP_256];
    assign bclk_c = strap_l.port_master ? bclk_m : l.pf[LP_BIT_CLK];
    assign wclk_c = strap_l.port_master ? wclk_m : l.pf[LP_WORD_CLK];
    assign bclk_fall = l.bclk_prev & ~bclk_c;
    // word clock high carries the left word
    assign load = wclk_c ? {FRAME.left, PAD_ZERO} : {FRAME.right, PAD_ZERO};

    always_comb begin
        next_l = l;
        // straps change on the same CLK edge as run rises, so the level filter passes them together
        next_l.x1 = {~s.low_power, s.strap};
        next_l.x2 = l.x1;
        next_l.x3 = l.x2;
        next_l.xf = next_xf;
        next_l.p1 = {SERIAL_OUT_WORD_CLOCK_IN, SERIAL_OUT_BIT_CLOCK_IN};
        next_l.p2 = l.p1;
        next_l.p3 = l.p2;
        next_l.pf = next_pf;
        next_l.div = run_l ? l.div + 8'h01 : 8'h00;
        next_l.bclk_prev = bclk_c;
        if (!run_l) begin
            next_l.shift = '0;
            next_l.sdata = 1'b0;
            next_l.wclk_prev = wclk_c;
        end else if (bclk_fall) begin
            next_l.wclk_prev = wclk_c;
            if (wclk_c != l.wclk_prev) begin
                next_l.sdata = load[SLOT_W-1];
                next_l.shift = {load[SLOT_W-2:0], 1'b0};
            end else begin
                next_l.sdata = l.shift[SLOT_W-1];
                next_l.shift = {l.shift[SLOT_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge MASTER_CLK or negedge lrst_n) begin
        if (!lrst_n) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign SERIAL_OUT_BIT_CLOCK_OUT = bclk_m;
    assign SERIAL_OUT_WORD_CLOCK_OUT = wclk_m;
    assign SERIAL_OUT_BIT_CLOCK_OE = run_l & strap_l.port_master;
    assign SERIAL_OUT_WORD_CLOCK_OE = run_l & strap_l.port_master;
    assign SERIAL_OUT_DATA_OUT = l.sdata;
    assign SERIAL_OUT_DATA_OE = run_l;

    // system clock domain checks
    chk_low_power: assert property (@(posedge CLK) disable iff (!RST_N)
        (s.st != ST_RUN) |-> LOW_POWER)
        else $error("low power dropped before straps were taken");
    chk_strap_take: assert property (@(posedge CLK) disable iff (!RST_N)
        (s.st == ST_SAMPLE) |=> (HW_MODE == !$past(s.f[SY_DATA_STRAP]))
        && BLOCK_START_INDICATOR_OE && !LOW_POWER)
        else $error("strap not taken on leaving sample state");
    chk_strap_input: assert property (@(posedge CLK) disable iff (!RST_N)
        (s.st == ST_SETTLE) |-> !BLOCK_START_INDICATOR_OE && !SIDEBAND_BITS_OE)
        else $error("strap pin driven during sensing");
    chk_enable_edge: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(s.local_en) |-> $past(sys_rise) && $past(s.st == ST_RUN))
        else $error("local clock mode without a rising edge");
    chk_unlock_route: assert property (@(posedge CLK) disable iff (!RST_N)
        (s.st == ST_RUN && s.local_en && !s.f[SY_PLL_LOCK])
        |=> LOCAL_CLOCK_ACTIVE ##0
        (RECOVERED_MASTER_CLOCK == SYSTEM_CLOCK_IN))
        else $error("system clock not routed on unlock");
    chk_rx_mux: assert property (@(posedge CLK) disable iff (!RST_N)
        (s.st == ST_RUN && HW_MODE) ##1 (s.st == ST_RUN) |->
        RECEIVER_LINE == POSITIVE_LINE_INPUTS[$past(s.f[SY_RX_SEL +: 2])])
        else $error("receiver mux picks wrong line");
    chk_pass_mux: assert property (@(posedge CLK) disable iff (!RST_N)
        (s.st == ST_RUN && HW_MODE) ##1 (s.st == ST_RUN)
        |-> s.sel.pass_sel == $past(s.f[SY_PASS_SEL +: 2]))
        else $error("passthrough select not following its pins");
    chk_mux_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
        (LOW_POWER || !HW_MODE) |-> !RECEIVER_LINE && !PASSTHROUGH_OUT)
        else $error("line mux live outside hardware mode");
    // link clock domain checks
    chk_bit_rate: assert property (@(posedge MASTER_CLK) disable iff (!lrst_n)
        (run_l && strap_l.port_master && !strap_l.rate_128
        && $rose(SERIAL_OUT_BIT_CLOCK_OUT)) |=>
        SERIAL_OUT_BIT_CLOCK_OUT ##1 !SERIAL_OUT_BIT_CLOCK_OUT)
        else $error("bit clock not a quarter of master clock");
    chk_word_edge: assert property (@(posedge MASTER_CLK) disable iff (!lrst_n)
        (run_l && strap_l.port_master && $changed(SERIAL_OUT_WORD_CLOCK_OUT))
        |-> $fell(SERIAL_OUT_BIT_CLOCK_OUT))
        else $error("word clock moved off a bit clock fall");
    chk_data_shift: assert property (@(posedge MASTER_CLK) disable iff (!lrst_n)
        (run_l && bclk_fall && wclk_c == l.wclk_prev)
        |=> SERIAL_OUT_DATA_OUT == $past(l.shift[SLOT_W-1]))
        else $error("serial data not shifted on bit clock fall");

    cov_route: cover property (@(posedge CLK) disable iff (!RST_N)
        $rose(LOCAL_CLOCK_ACTIVE));
    cov_hw_run: cover property (@(posedge CLK) disable iff (!RST_N)
        $fell(LOW_POWER) && HW_MODE);
    cov_master_word: cover property (@(posedge MASTER_CLK)
        disable iff (!lrst_n)
        run_l && strap_l.port_master && $rose(SERIAL_OUT_WORD_CLOCK_OUT));
    cov_slave_load: cover property (@(posedge MASTER_CLK)
        disable iff (!lrst_n)
        run_l && !strap_l.port_master && bclk_fall && wclk_c != l.wclk_prev);
    cov_fast_word: cover property (@(posedge MASTER_CLK)
        disable iff (!lrst_n)
        run_l && strap_l.rate_128 && $rose(SERIAL_OUT_WORD_CLOCK_OUT));
endmodule : hwm_top

// ==== verification/hwm_audio_sink.sv ====
`timescale 1ns/1ns
module hwm_audio_sink
    import hwm_pkg::*;
(
    // link side wires
    input wire logic mclk,
    input wire logic bit_clk,
    input wire logic word_clk,
    input wire logic data,
    // clocks the far side drives while the block is a slave
    output logic bit_out,
    output logic word_out,
    // captured words
    output hwm_frame_t got,
    output logic [15:0] word_period,
    output logic [7:0] n_words
);
    logic bit_d = 1'b0;
    logic word_d = 1'b0;
    logic word_prev = 1'b0;
    logic [4:0] bit_n = 5'h00;
    logic [WORD_W-1:0] acc = '0;
    logic [15:0] mcnt = 16'h0000;
    logic [9:0] gen = 10'h000;
    // 16 link clocks a bit, 32 bits a word: slow enough for the
    // block's pin filter, and the word moves on a bit clock fall
    assign bit_out = gen[3];
    assign word_out = gen[9];
    initial begin
        got = '0;
        word_period = 16'h0000;
        n_words = 8'h00;
    end
    // pins sampled on the link clock: a bit is taken one edge after the
    // rise, so data launched on that same edge cannot race the capture
    always @(posedge mclk) begin
        gen <= gen + 10'h001;
        bit_d <= bit_clk;
        word_d <= word_clk;
        if (word_clk && !word_d) begin
            word_period <= mcnt;
            mcnt <= 16'h0001;
        end else begin
            mcnt <= mcnt + 16'h0001;
        end
        if (bit_clk && !bit_d) begin
            word_prev <= word_clk;
            acc <= {acc[WORD_W-2:0], data};
            if (word_clk != word_prev) begin
                bit_n <= 5'h01;
            end else if (bit_n != 5'h00 && bit_n < 5'(WORD_W)) begin
                bit_n <= bit_n + 5'h01;
                if (bit_n == 5'(WORD_W - 1)) begin
                    if (word_clk) begin
                        got.left <= {acc[WORD_W-2:0], data};
                    end else begin
                        got.right <= {acc[WORD_W-2:0], data};
                    end
                    n_words <= n_words + 8'h01;
                end
            end
        end
    end
endmodule : hwm_audio_sink

// ==== verification/test_hwm_top.sv ====
`timescale 1ns/1ns
module test_hwm_top;
    import hwm_pkg::*;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic MASTER_CLK = 1'b0;
    logic [3:0] POSITIVE_LINE_INPUTS = 4'h0;
    logic [1:0] RECEIVER_INPUT_SELECT = 2'h0;
    logic [1:0] PASSTHROUGH_SELECT = 2'h0;
    logic SYSTEM_CLOCK_IN = 1'b0;
    logic PLL_LOCKED = 1'b0;
    logic BLOCK_START_VALUE = 1'b0;
    logic SIDEBAND_VALUE = 1'b0;
    hwm_frame_t FRAME = 48'h0;
    logic RECEIVER_LINE, PASSTHROUGH_OUT, RECOVERED_MASTER_CLOCK;
    logic LOCAL_CLOCK_ACTIVE, HW_MODE, PLL_RATE_128, PORT_MASTER, LOW_POWER;
    logic BLOCK_START_INDICATOR_IN, BLOCK_START_INDICATOR_OUT;
    logic BLOCK_START_INDICATOR_OE, SIDEBAND_BITS_IN, SIDEBAND_BITS_OUT;
    logic SIDEBAND_BITS_OE, SERIAL_OUT_BIT_CLOCK_IN;
    logic SERIAL_OUT_BIT_CLOCK_OUT, SERIAL_OUT_BIT_CLOCK_OE;
    logic SERIAL_OUT_WORD_CLOCK_IN, SERIAL_OUT_WORD_CLOCK_OUT;
    logic SERIAL_OUT_WORD_CLOCK_OE, SERIAL_OUT_DATA_IN;
    logic SERIAL_OUT_DATA_OUT, SERIAL_OUT_DATA_OE;
    logic blk_pull = 1'b1;
    logic side_pull = 1'b0;
    logic dat_pull = 1'b0;
    hwm_frame_t got;
    logic [15:0] word_period;
    logic [7:0] n_words;
    logic slv_bit;
    logic slv_word;
    int n_errors = 0;
    int n_compared = 0;
    // strap resistors hold the pins while the block is not driving them
    assign BLOCK_START_INDICATOR_IN = BLOCK_START_INDICATOR_OE ?
        BLOCK_START_INDICATOR_OUT : blk_pull;
    assign SIDEBAND_BITS_IN = SIDEBAND_BITS_OE ? SIDEBAND_BITS_OUT : side_pull;
    assign SERIAL_OUT_DATA_IN = SERIAL_OUT_DATA_OE ?
        SERIAL_OUT_DATA_OUT : dat_pull;
    // the far side drives the port clocks whenever the block does not
    assign SERIAL_OUT_BIT_CLOCK_IN = SERIAL_OUT_BIT_CLOCK_OE ?
        SERIAL_OUT_BIT_CLOCK_OUT : slv_bit;
    assign SERIAL_OUT_WORD_CLOCK_IN = SERIAL_OUT_WORD_CLOCK_OE ?
        SERIAL_OUT_WORD_CLOCK_OUT : slv_word;
    initial begin
        forever #25 CLK = ~CLK;
    end
    initial begin
        #4;
        forever begin
            MASTER_CLK = 1'b1;
            #7;
            MASTER_CLK = 1'b0;
            #8;
        end
    end
    hwm_top u_hwm_top (.CLK, .RST_N, .MASTER_CLK, .POSITIVE_LINE_INPUTS,
        .RECEIVER_INPUT_SELECT, .PASSTHROUGH_SELECT, .RECEIVER_LINE,
        .PASSTHROUGH_OUT, .SYSTEM_CLOCK_IN, .PLL_LOCKED,
        .RECOVERED_MASTER_CLOCK, .LOCAL_CLOCK_ACTIVE,
        .BLOCK_START_INDICATOR_IN, .BLOCK_START_INDICATOR_OUT,
        .BLOCK_START_INDICATOR_OE, .BLOCK_START_VALUE, .SIDEBAND_BITS_IN,
        .SIDEBAND_BITS_OUT, .SIDEBAND_BITS_OE, .SIDEBAND_VALUE,
        .SERIAL_OUT_BIT_CLOCK_IN, .SERIAL_OUT_BIT_CLOCK_OUT,
        .SERIAL_OUT_BIT_CLOCK_OE, .SERIAL_OUT_WORD_CLOCK_IN,
        .SERIAL_OUT_WORD_CLOCK_OUT, .SERIAL_OUT_WORD_CLOCK_OE,
        .SERIAL_OUT_DATA_IN, .SERIAL_OUT_DATA_OUT, .SERIAL_OUT_DATA_OE,
        .FRAME, .HW_MODE, .PLL_RATE_128, .PORT_MASTER, .LOW_POWER);
    hwm_audio_sink u_hwm_audio_sink (.mclk(MASTER_CLK),
        .bit_clk(SERIAL_OUT_BIT_CLOCK_IN), .word_clk(SERIAL_OUT_WORD_CLOCK_IN),
        .data(SERIAL_OUT_DATA_IN), .bit_out(slv_bit), .word_out(slv_word),
        .got(got), .word_period(word_period),
        .n_words(n_words));
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_up(input string what);
        n_errors++;
        $display("BAD %s expected done seen timeout", what);
        summarize();
    endtask : give_up
    task automatic do_reset(input logic side, input logic blk,
        input logic dat);
        int i;
        @(posedge CLK);
        RST_N <= 1'b0;
        side_pull <= side;
        blk_pull <= blk;
        dat_pull <= dat;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        check("low_power", LOW_POWER, 1'b1);
        check("oe", {BLOCK_START_INDICATOR_OE, SIDEBAND_BITS_OE}, 2'h0);
        check("rx_line", RECEIVER_LINE, 1'b0);
        @(posedge CLK);
        RST_N <= 1'b1;
        for (i = 0; i < 20 && LOW_POWER !== 1'b0; i++) @(negedge CLK);
        if (LOW_POWER !== 1'b0) give_up("start");
        repeat (2) @(negedge CLK);
        check("hw_mode", HW_MODE, !dat);
        check("rate", PLL_RATE_128, side);
        check("master", PORT_MASTER, blk);
        check("bclk_oe", SERIAL_OUT_BIT_CLOCK_OE, blk);
        check("oe", {BLOCK_START_INDICATOR_OE, SIDEBAND_BITS_OE}, 2'h3);
        $display("reset done");
    endtask : do_reset
    task automatic strap_echo();
        @(posedge CLK);
        BLOCK_START_VALUE <= 1'b0;
        SIDEBAND_VALUE <= 1'b1;
        repeat (2) @(negedge CLK);
        check("blk_pin", BLOCK_START_INDICATOR_IN, 1'b0);
        check("side_pin", SIDEBAND_BITS_IN, 1'b1);
        $display("strap echo done");
    endtask : strap_echo
    task automatic mux_sweep();
        int r, p, k;
        for (r = 0; r < 4; r++) begin
            for (p = 0; p < 4; p++) begin
                @(posedge CLK);
                RECEIVER_INPUT_SELECT <= 2'(r);
                PASSTHROUGH_SELECT <= 2'(p);
                repeat (8) @(posedge CLK);
                for (k = 0; k < 4; k++) begin
                    POSITIVE_LINE_INPUTS <= 4'(1 << k);
                    @(negedge CLK);
                    check("rx_line", RECEIVER_LINE, 1'(k == r));
                    check("pass", PASSTHROUGH_OUT, 1'(k == p));
                    @(posedge CLK);
                end
            end
        end
        // park passthrough on a line the receiver leaves free
        @(posedge CLK);
        RECEIVER_INPUT_SELECT <= 2'h0;
        PASSTHROUGH_SELECT <= 2'h3;
        $display("mux sweep done");
    endtask : mux_sweep
    task automatic local_clock();
        int i;
        repeat (6) @(negedge CLK);
        check("local", LOCAL_CLOCK_ACTIVE, 1'b0);
        repeat (4) begin
            @(posedge CLK);
            SYSTEM_CLOCK_IN <= ~SYSTEM_CLOCK_IN;
            repeat (3) @(posedge CLK);
        end
        for (i = 0; i < 12 && LOCAL_CLOCK_ACTIVE !== 1'b1; i++) @(negedge CLK);
        if (LOCAL_CLOCK_ACTIVE !== 1'b1) give_up("local on");
        check("local", LOCAL_CLOCK_ACTIVE, 1'b1);
        @(posedge CLK);
        SYSTEM_CLOCK_IN <= 1'b1;
        @(negedge CLK);
        check("recovered_master_clock", RECOVERED_MASTER_CLOCK, 1'b1);
        @(posedge CLK);
        SYSTEM_CLOCK_IN <= 1'b0;
        PLL_LOCKED <= 1'b1;
        @(negedge CLK);
        check("recovered_master_clock", RECOVERED_MASTER_CLOCK, 1'b0);
        for (i = 0; i < 12 && LOCAL_CLOCK_ACTIVE !== 1'b0; i++) @(negedge CLK);
        if (LOCAL_CLOCK_ACTIVE !== 1'b0) give_up("local off");
        check("local", LOCAL_CLOCK_ACTIVE, 1'b0);
        check("recovered_master_clock", RECOVERED_MASTER_CLOCK, MASTER_CLK);
        $display("local clock done");
    endtask : local_clock
    task automatic serial_words(input logic side, input logic master);
        logic [7:0] start;
        logic [15:0] per;
        hwm_frame_t exp;
        int i;
        exp = !master ? {24'h2468AC, 24'hDB9753}
            : side ? {24'h5A0FC3, 24'hA5F03C} : {24'hC0FFEE, 24'h13579B};
        // slave words are timed by the far side's own divider
        per = !master ? 16'h0400 : side ? 16'h0080 : 16'h0100;
        // the frame belongs to the link clock
        @(posedge MASTER_CLK);
        FRAME <= exp;
        start = n_words;
        for (i = 0; i < 2000 && 8'(n_words - start) < 8'h05; i++)
            @(negedge CLK);
        if (8'(n_words - start) < 8'h05) give_up("words");
        check("left", got.left, exp.left);
        check("right", got.right, exp.right);
        check("period", word_period, per);
        check("word_oe", SERIAL_OUT_WORD_CLOCK_OE, master);
        $display("serial words done");
    endtask : serial_words
    task automatic register_mode();
        @(posedge CLK);
        POSITIVE_LINE_INPUTS <= 4'hF;
        RECEIVER_INPUT_SELECT <= 2'h1;
        PASSTHROUGH_SELECT <= 2'h2;
        repeat (8) @(negedge CLK);
        check("rx_line", RECEIVER_LINE, 1'b0);
        check("pass", PASSTHROUGH_OUT, 1'b0);
        $display("register mode done");
    endtask : register_mode
    initial begin
        do_reset(1'b0, 1'b1, 1'b0);
        strap_echo();
        mux_sweep();
        local_clock();
        serial_words(1'b0, 1'b1);
        do_reset(1'b1, 1'b1, 1'b0);
        serial_words(1'b1, 1'b1);
        do_reset(1'b0, 1'b0, 1'b0);
        serial_words(1'b0, 1'b0);
        do_reset(1'b0, 1'b0, 1'b1);
        register_mode();
        summarize();
    end
endmodule : test_hwm_top
